// *** ack_shift_register.sv ***
// acknowledge shift register with selectable wait-state tap
module ack_shift_register #(
	parameter int TAPS = 4,
	parameter int SPACING = 2
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// control
	input wire logic run_i,
	input wire logic [1:0] tap_sel_i,
	// acknowledge
	output logic ack_o
);
	import arbiter_pkg::*;

	localparam int LEN = (TAPS - 1) * SPACING + 1;

	// refuse sizes that the shift chain or the 2-bit tap decode cannot serve
	if (TAPS < 2 || TAPS > 4 || SPACING < 1) begin : g_bad_size
		$error("ack_shift_register: unsupported parameters");
	end

	logic [LEN-1:0] shift_r;

	// shift ones while running; clear at once when the access ends
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			shift_r <= '0;
		end else if (!run_i) begin
			shift_r <= '0;
		end else begin
			shift_r <= {shift_r[LEN-2:0], 1'b1};
		end
	end

	// tap select: tap k asserts SPACING*k cycles after the first
	always_comb begin
		ack_o = run_i & shift_r[int'(tap_sel_i) * SPACING];
	end

endmodule : ack_shift_register

// *** arbiter_chk.sv ***
// checker: handover order and acknowledge timing of the arbiter
module arbiter_chk #(
	parameter logic [1:0] ACK_TAP = 2'h1
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// watched ports
	input wire logic cpu_as_n_i,
	input wire logic video_in_window_i,
	input wire logic transfer_acknowledge_n_o,
	input wire logic [3:0] video_mode_o,
	input wire logic video_frame_sync_o,
	input wire logic mem_we_o,
	input wire arbiter_pkg::mem_ctrl_t mem_ctrl_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import arbiter_pkg::*;
	localparam int ACK_DLY = 2 + 2 * ACK_TAP;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// ==========================================================
	// handover steps
	sequence s_isolate;
		!mem_ctrl_o.video_addr_oe && !mem_ctrl_o.cpu_buf_oe;
	endsequence
	sequence s_deselect;
		!mem_ctrl_o.video_dec_en && !mem_ctrl_o.cpu_buf_oe;
	endsequence
	property p_order;
		$rose(mem_ctrl_o.cpu_sel) |-> s_isolate ##1 s_deselect
			##1 mem_ctrl_o.cpu_buf_oe;
	endproperty
	a_order: assert property (p_order) else $error("handover order");
	property p_one_master;
		mem_ctrl_o.cpu_buf_oe |-> mem_ctrl_o.cpu_sel
			&& !mem_ctrl_o.video_addr_oe && !mem_ctrl_o.video_dec_en;
	endproperty
	a_one_master: assert property (p_one_master) else $error("two masters");
	property p_ack_wait;
		$rose(mem_ctrl_o.cpu_buf_oe) |->
			##[ACK_DLY:ACK_DLY] $fell(transfer_acknowledge_n_o);
	endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("ack delay");
	property p_ack_clear;
		cpu_as_n_i [*4] |-> transfer_acknowledge_n_o;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("ack held");
	property p_idle;
		cpu_as_n_i [*8] |-> !mem_ctrl_o.cpu_buf_oe && !mem_ctrl_o.cpu_sel
			&& mem_ctrl_o.video_addr_oe && mem_ctrl_o.video_dec_en;
	endproperty
	a_idle: assert property (p_idle) else $error("idle bus");
	property p_we_owner;
		mem_we_o |-> mem_ctrl_o.cpu_buf_oe && mem_ctrl_o.cpu_data_dir_wr;
	endproperty
	a_we_owner: assert property (p_we_owner) else $error("stray write");
	property p_mode_hold;
		cpu_as_n_i [*8] |=> $stable(video_mode_o);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
	property p_sync_low;
		!video_in_window_i [*4] |-> !video_frame_sync_o;
	endproperty
	a_sync_low: assert property (p_sync_low) else $error("sync high");
endmodule : arbiter_chk

bind display_memory_arbiter arbiter_chk #(.ACK_TAP(ACK_TAP)) u_chk (
	.clock_i(clock_i),
	.reset_i(reset_i),
	.cpu_as_n_i(cpu_as_n_i),
	.video_in_window_i(video_in_window_i),
	.transfer_acknowledge_n_o(transfer_acknowledge_n_o),
	.video_mode_o(video_mode_o),
	.video_frame_sync_o(video_frame_sync_o),
	.mem_we_o(mem_we_o),
	.mem_ctrl_o(mem_ctrl_o)
);

// *** arbiter_pkg.sv ***
// package: constants and carrier types for the shared display memory arbiter
package arbiter_pkg;

	// ==========================================================
	// widths
	localparam int CPU_ADDR_W = 23;
	localparam int MEM_ADDR_W = 13;
	localparam int MEM_DATA_W = 12;
	localparam int MODE_W = 4;
	localparam int CPU_DATA_W = 16;

	// ==========================================================
	// region decode: 6K words starting at a base word address
	localparam logic [22:0] REGION_BASE = 23'h000000;
	localparam logic [22:0] REGION_SIZE = 23'h001800;

	// ==========================================================
	// mode latch field positions in the processor data word
	localparam int MODE_LSB = 12;
	localparam logic [3:0] MODE_RESET = 4'h0;

	// ==========================================================
	// acknowledge taps: wait states per tap
	localparam int NUM_TAPS = 4;
	localparam logic [1:0] TAP_ZERO_WAIT = 2'h0;
	localparam logic [1:0] TAP_TWO_WAIT = 2'h1;
	localparam logic [1:0] TAP_FOUR_WAIT = 2'h2;
	localparam logic [1:0] TAP_SIX_WAIT = 2'h3;
	localparam int WAITS_PER_TAP = 2;

	// ==========================================================
	// handover sequence states
	typedef enum logic [2:0] {
		ST_VIDEO = 3'b000,
		ST_ISOLATE = 3'b001,
		ST_DESELECT = 3'b010,
		ST_CONNECT = 3'b011,
		ST_RELEASE = 3'b100
	} arb_state_t;

	// processor bus request
	typedef struct packed {
		logic as_n;
		logic rw;
		logic [22:0] addr;
		logic [15:0] wdata;
	} cpu_req_t;

	// memory bus as driven toward the display memory
	typedef struct packed {
		logic cpu_sel;
		logic video_addr_oe;
		logic video_dec_en;
		logic cpu_buf_oe;
		logic cpu_data_dir_wr;
	} mem_ctrl_t;

endpackage : arbiter_pkg

// *** cpu_bus_model.sv ***
// partner: processor bus master issuing display memory accesses
module cpu_bus_model (
	// clock
	input wire logic clock_i,
	// processor bus pins
	output logic as_n_o,
	output logic rw_o,
	output logic [22:0] addr_o,
	output logic [15:0] wdata_o,
	input wire logic ack_n_i,
	input wire logic frame_sync_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// idle bus
	initial begin
		as_n_o = 1'b1;
		rw_o = 1'b1;
		addr_o = 23'h000000;
		wdata_o = 16'h0000;
	end
	// start an access, count edges to acknowledge, -1 on none
	task automatic start(input logic rw, input logic [22:0] a,
		input logic [15:0] d, output int n);
		while (!rw && frame_sync_i) @(negedge clock_i);
		@(negedge clock_i);
		rw_o = rw;
		addr_o = a;
		wdata_o = d;
		as_n_o = 1'b0;
		n = -1;
		for (int i = 1; i < 40 && n < 0; i++) begin
			@(posedge clock_i);
			#1;
			if (ack_n_i === 1'b0) n = i;
		end
	endtask : start
	// end the access; released lines show inverted values
	task automatic stop();
		@(negedge clock_i);
		as_n_o = 1'b1;
		rw_o = 1'b1;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
		repeat (10) @(negedge clock_i);
	endtask : stop
endmodule : cpu_bus_model

// *** display_memory_arbiter.sv ***
// top: shared display memory arbiter between processor and video generator
module display_memory_arbiter #(
	parameter logic [1:0] ACK_TAP = arbiter_pkg::TAP_TWO_WAIT
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// processor bus (pins, asynchronous)
	input wire logic cpu_as_n_i,
	input wire logic cpu_rw_i,
	input wire logic [arbiter_pkg::CPU_ADDR_W-1:0] cpu_addr_i,
	input wire logic [arbiter_pkg::CPU_DATA_W-1:0] cpu_wdata_i,
	output logic transfer_acknowledge_n_o,
	output logic [arbiter_pkg::MEM_DATA_W-1:0] cpu_rdata_o,
	// video display generator side
	input wire logic [arbiter_pkg::MEM_ADDR_W-1:0] video_addr_i,
	input wire logic video_in_window_i,
	output logic [arbiter_pkg::MEM_DATA_W-1:0] video_rdata_o,
	output logic [arbiter_pkg::MODE_W-1:0] video_mode_o,
	output logic video_frame_sync_o,
	// display memory port
	output logic [arbiter_pkg::MEM_ADDR_W-1:0] mem_addr_o,
	output logic [arbiter_pkg::MEM_DATA_W-1:0] mem_wdata_o,
	output logic mem_wdata_oe_o,
	output logic mem_we_o,
	input wire logic [arbiter_pkg::MEM_DATA_W-1:0] mem_rdata_i,
	// bus ownership status
	output arbiter_pkg::mem_ctrl_t mem_ctrl_o
);
	import arbiter_pkg::*;

	// refuse a tap beyond the last one the shift register provides
	if (int'(ACK_TAP) >= NUM_TAPS) begin : g_bad_tap
		$error("display_memory_arbiter: bad ACK_TAP");
	end

	// ==========================================================
	// input synchronisers
	cpu_req_t req_s1_r;
	cpu_req_t req_r;
	logic win_s1_r;
	logic win_r;

	// two flip-flops on every processor pin
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			req_s1_r <= '{as_n: 1'b1, rw: 1'b1, addr: '0, wdata: '0};
			req_r <= '{as_n: 1'b1, rw: 1'b1, addr: '0, wdata: '0};
		end else begin
			req_s1_r <= '{as_n: cpu_as_n_i, rw: cpu_rw_i,
				addr: cpu_addr_i, wdata: cpu_wdata_i};
			req_r <= req_s1_r;
		end
	end

	// two flip-flops on the video window level
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			win_s1_r <= 1'b0;
			win_r <= 1'b0;
		end else begin
			win_s1_r <= video_in_window_i;
			win_r <= win_s1_r;
		end
	end

	// ==========================================================
	// region decode
	function automatic logic in_region(input logic [22:0] a);
		in_region = (a >= REGION_BASE) && (a < REGION_BASE + REGION_SIZE);
	endfunction : in_region

	logic hit;
	assign hit = !req_r.as_n && in_region(req_r.addr);

	// ==========================================================
	// handover sequencer
	arb_state_t state_r;
	arb_state_t state_nxt;
	logic ack;

	// next state: ordered handover and release
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_VIDEO: begin
				if (hit)
					state_nxt = ST_ISOLATE;
			end
			ST_ISOLATE: begin
				state_nxt = hit ? ST_DESELECT : ST_RELEASE;
			end
			ST_DESELECT: begin
				state_nxt = hit ? ST_CONNECT : ST_RELEASE;
			end
			ST_CONNECT: begin
				if (!hit)
					state_nxt = ST_RELEASE;
			end
			ST_RELEASE: begin
				state_nxt = ST_VIDEO;
			end
			default: begin
				state_nxt = ST_VIDEO;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ST_VIDEO;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// bus ownership controls, registered
	mem_ctrl_t ctrl_r;
	mem_ctrl_t ctrl_nxt;

	// video owns bus only in ST_VIDEO; processor only in ST_CONNECT
	always_comb begin
		ctrl_nxt.cpu_sel = (state_nxt != ST_VIDEO);
		ctrl_nxt.video_addr_oe = (state_nxt == ST_VIDEO);
		ctrl_nxt.video_dec_en = (state_nxt == ST_VIDEO) ||
			(state_nxt == ST_ISOLATE) ||
			(state_nxt == ST_RELEASE && state_r != ST_CONNECT);
		ctrl_nxt.cpu_buf_oe = (state_nxt == ST_CONNECT) && hit;
		ctrl_nxt.cpu_data_dir_wr = (state_nxt == ST_CONNECT) && !req_r.rw;
	end

	// registered controls so every transition lands cleanly
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_r <= '{cpu_sel: 1'b0, video_addr_oe: 1'b1,
				video_dec_en: 1'b1, cpu_buf_oe: 1'b0,
				cpu_data_dir_wr: 1'b0};
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	assign mem_ctrl_o = ctrl_r;

	// ==========================================================
	// memory bus mux: one source only
	logic [MEM_ADDR_W-1:0] mem_addr_r;
	logic [MEM_DATA_W-1:0] mem_wdata_r;
	logic mem_we_r;

	// address follows the current owner; write data is loaded from the processor every cycle
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			mem_addr_r <= '0;
			mem_wdata_r <= '0;
			mem_we_r <= 1'b0;
		end else begin
			if (ctrl_nxt.cpu_buf_oe) begin
				mem_addr_r <= req_r.addr[MEM_ADDR_W-1:0];
			end else if (ctrl_nxt.video_addr_oe) begin
				mem_addr_r <= video_addr_i;
			end
			mem_wdata_r <= req_r.wdata[MEM_DATA_W-1:0];
			mem_we_r <= ctrl_nxt.cpu_buf_oe && !req_r.rw;
		end
	end

	assign mem_addr_o = mem_addr_r;
	assign mem_wdata_o = mem_wdata_r;
	assign mem_wdata_oe_o = ctrl_r.cpu_data_dir_wr;
	assign mem_we_o = mem_we_r;

	// ==========================================================
	// read data returned to the requesting side
	logic [MEM_DATA_W-1:0] cpu_rdata_r;
	logic [MEM_DATA_W-1:0] video_rdata_r;

	// capture read data for whichever master owns the bus
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cpu_rdata_r <= '0;
			video_rdata_r <= '0;
		end else begin
			if (ctrl_r.cpu_buf_oe && req_r.rw)
				cpu_rdata_r <= mem_rdata_i;
			if (ctrl_r.video_addr_oe)
				video_rdata_r <= mem_rdata_i;
		end
	end

	assign cpu_rdata_o = cpu_rdata_r;
	assign video_rdata_o = video_rdata_r;

	// ==========================================================
	// mode latch: loaded by even-address processor writes only
	logic [MODE_W-1:0] mode_r;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			mode_r <= MODE_RESET;
		end else if (ctrl_r.cpu_buf_oe && !req_r.rw && !req_r.addr[0]) begin
			mode_r <= req_r.wdata[MODE_LSB +: MODE_W];
		end
	end

	assign video_mode_o = mode_r;

	// ==========================================================
	// frame sync: follows the active window level three clocks late
	logic fsync_r;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			fsync_r <= 1'b0;
		end else begin
			fsync_r <= win_r;
		end
	end

	assign video_frame_sync_o = fsync_r;

	// ==========================================================
	// transfer acknowledge from the shift register
	ack_shift_register #(
		.TAPS(NUM_TAPS),
		.SPACING(WAITS_PER_TAP)
	) u_ack (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.run_i(ctrl_r.cpu_buf_oe),
		.tap_sel_i(ACK_TAP),
		.ack_o(ack)
	);

	logic ack_n_r;

	// acknowledge negated as soon as the access ends
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ack_n_r <= 1'b1;
		end else begin
			ack_n_r <= !(ack && hit);
		end
	end

	assign transfer_acknowledge_n_o = ack_n_r;

endmodule : display_memory_arbiter

// *** tb.sv ***
// testbench: processor accesses through the display memory arbiter
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import arbiter_pkg::*;
	localparam logic [1:0] TAP = TAP_TWO_WAIT;
	logic clock_i, reset_i, as_n, rw, ack_n, win, fsync, oe, we;
	logic ack0_n;
	int n_lead = 0;
	logic [22:0] addr;
	logic [15:0] wdata;
	logic [11:0] rdata, vrdata, mwdata, mrdata;
	logic [12:0] vaddr, maddr;
	logic [3:0] mode;
	mem_ctrl_t ctrl;
	int n_fail = 0;
	int n_checks = 0;
	int n;
	always #5 clock_i = ~clock_i;
	display_memory_arbiter #(.ACK_TAP(TAP)) u_dut (.clock_i(clock_i),
		.reset_i(reset_i), .cpu_as_n_i(as_n), .cpu_rw_i(rw),
		.cpu_addr_i(addr), .cpu_wdata_i(wdata),
		.transfer_acknowledge_n_o(ack_n), .cpu_rdata_o(rdata),
		.video_addr_i(vaddr), .video_in_window_i(win),
		.video_rdata_o(vrdata), .video_mode_o(mode),
		.video_frame_sync_o(fsync), .mem_addr_o(maddr),
		.mem_wdata_o(mwdata), .mem_wdata_oe_o(oe), .mem_we_o(we),
		.mem_rdata_i(mrdata), .mem_ctrl_o(ctrl));
	// second arbiter on the same pins, acknowledge from the first tap
	display_memory_arbiter #(.ACK_TAP(TAP_ZERO_WAIT)) u_dut0 (
		.clock_i(clock_i), .reset_i(reset_i), .cpu_as_n_i(as_n),
		.cpu_rw_i(rw), .cpu_addr_i(addr), .cpu_wdata_i(wdata),
		.transfer_acknowledge_n_o(ack0_n), .cpu_rdata_o(),
		.video_addr_i(vaddr), .video_in_window_i(win),
		.video_rdata_o(), .video_mode_o(), .video_frame_sync_o(),
		.mem_addr_o(), .mem_wdata_o(), .mem_wdata_oe_o(), .mem_we_o(),
		.mem_rdata_i(mrdata), .mem_ctrl_o());
	// cycles in which the zero-wait acknowledge leads the slower one
	always @(negedge clock_i) begin
		if (ack0_n === 1'b0 && ack_n === 1'b1)
			n_lead++;
	end
	cpu_bus_model u_cpu (.clock_i(clock_i), .as_n_o(as_n), .rw_o(rw),
		.addr_o(addr), .wdata_o(wdata), .ack_n_i(ack_n),
		.frame_sync_i(fsync));
	// ==========================================================
	// compare and verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	// ==========================================================
	// scenarios
	task automatic t_idle();
		repeat (4) @(negedge clock_i);
		chk(16'(ctrl[4:1]), 16'h6);
		chk(16'(maddr), 16'h0AB);
		chk(16'(vrdata), 16'h9E1);
		chk(16'({ack_n, mode}), 16'h10);
		$display("idle done");
	endtask : t_idle
	task automatic t_sync();
		win = 1'b1;
		repeat (4) @(negedge clock_i);
		chk(16'(fsync), 16'h1);
		win = 1'b0;
		repeat (4) @(negedge clock_i);
		chk(16'(fsync), 16'h0);
		$display("sync done");
	endtask : t_sync
	task automatic t_writes();
		u_cpu.start(1'b0, 23'h000010, 16'hA5C3, n);
		chk(16'(n), 16'(7 + 2 * TAP));
		chk(16'(n_lead), 16'(2 * TAP));
		chk(16'(n - n_lead), 16'h7);
		chk(16'({we, oe, ctrl.cpu_buf_oe, mwdata}), 16'h75C3);
		u_cpu.stop();
		chk(16'(mode), 16'hA);
		u_cpu.start(1'b0, 23'h000011, 16'h3456, n);
		chk(16'(n), 16'(7 + 2 * TAP));
		u_cpu.stop();
		chk(16'(mode), 16'hA);
		$display("writes done");
	endtask : t_writes
	task automatic t_read();
		mrdata = 12'h2C7;
		u_cpu.start(1'b1, 23'h0017FF, 16'h0000, n);
		chk(16'(n), 16'(7 + 2 * TAP));
		chk(16'(maddr), 16'h17FF);
		chk(16'({we, rdata}), 16'h02C7);
		u_cpu.stop();
		chk(16'(maddr), 16'h0AB);
		u_cpu.start(1'b1, 23'h001800, 16'h0000, n);
		chk(16'(n), 16'hFFFF);
		chk(16'(ctrl.cpu_sel), 16'h0);
		u_cpu.stop();
		$display("read done");
	endtask : t_read
	// ==========================================================
	// main sequence and watchdog
	initial begin
		clock_i = 1'b0;
		reset_i = 1'b1;
		win = 1'b0;
		vaddr = 13'h0AB;
		mrdata = 12'h9E1;
		repeat (5) @(negedge clock_i);
		reset_i = 1'b0;
		t_idle();
		t_sync();
		t_writes();
		t_read();
		complete_run();
	end
	initial begin
		#20000;
		n_fail++;
		complete_run();
	end
endmodule : tb
